/* inc/smpfs_params.svh */
// Constants of the stop-mode power-fail sequencer
`ifndef SMPFS_PARAMS_SVH
`define SMPFS_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and time base
// ----------------------------------------------------------------
`define SMPFS_CLK_MHZ        40
`define SMPFS_RING_PERIOD_NS 125000
`define SMPFS_RING_CYC       ((`SMPFS_RING_PERIOD_NS * `SMPFS_CLK_MHZ) / 1000)
`define SMPFS_XTAL_RDY_US    100
`define SMPFS_XTAL_CYC       (`SMPFS_XTAL_RDY_US * `SMPFS_CLK_MHZ)

// ----------------------------------------------------------------
// Periodic monitoring in ring-oscillator periods, wake settle in clocks
// ----------------------------------------------------------------
`define SMPFS_PER_BASE       2048
`define SMPFS_DET_RINGS      2
`define SMPFS_CONF_RINGS     1
`define SMPFS_WAKE_SETTLE    4

// ----------------------------------------------------------------
// Reset values and restart address
// ----------------------------------------------------------------
`define SMPFS_PFD_RST        1'b1
`define SMPFS_ROM_ADDR       16'h8000

`endif

/* inc/smpfs_pkg.sv */
// Types of the stop-mode power-fail sequencer
package smpfs_pkg;

  // Synchronised comparator outcomes, high while supply is above the threshold
  typedef struct packed {
    logic por_ok;
    logic rst_ok;
    logic warn_ok;
  } smpfs_cmp_t;

  // Power domain enables
  typedef struct packed {
    logic mon_en;
    logic reg_en;
    logic xtal_en;
    logic sram_ret;
  } smpfs_pwr_t;

  typedef enum logic [3:0] {
    ST_RUN      = 4'h0,
    ST_STOP_MON = 4'h1,
    ST_STOP_OFF = 4'h2,
    ST_WAKE_CHK = 4'h3,
    ST_WARM     = 4'h4,
    ST_PER_OFF  = 4'h5,
    ST_PER_DET  = 4'h6,
    ST_PER_CONF = 4'h7,
    ST_POR      = 4'h8
  } smpfs_state_t;

endpackage : smpfs_pkg

/* src/smpfs_sync.sv */
// Three-stage synchroniser with agreement filter for comparator inputs
`timescale 1ns/1ps
module smpfs_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          s1[i] <= INIT[i];
          s2[i] <= INIT[i];
          s3[i] <= INIT[i];
          q[i]  <= INIT[i];
        end else begin
          s1[i] <= d[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          // A change counts only once stages two and three agree
          if (s2[i] == s3[i]) begin
            q[i] <= s3[i];
          end
        end
      end
    end
  endgenerate

endmodule : smpfs_sync

/* src/smpfs_seq.sv */
// Stop-mode power-fail sequencer
//
// Behaviour
// - Stop with monitor enabled keeps monitor on, regulator and crystal off, SRAM retained, CPU halted.
// - A supply dip too short to resolve causes no warning and no state change in monitored stop.
// - Monitored stop with supply between reset and warning levels powers regulator and crystal, warms up, exits stop.
// - Monitored stop with supply between power-on and reset levels resets the CPU and starts periodic monitoring.
// - Below the power-on level the device is held in reset with monitor, regulator and crystal off.
// - Stop with monitor disabled keeps all three off and ignores warning and reset levels.
// - A wake interrupt with monitor disabled turns the monitor on and a warning level sets the power-fail flag.
// - That wake powers regulator and crystal, warms up, then vectors to the higher-priority interrupt.
// - A wake that finds the supply below the reset level resets the CPU and starts periodic monitoring.
// - The stop monitor disable control resets to one.
// - Periodic detection lasts two ring periods, confirms for a third, then releases reset to ROM after warm-up.
`timescale 1ns/1ps
`include "smpfs_params.svh"
module smpfs_seq #(
  parameter int RING_CYC = `SMPFS_RING_CYC,
  parameter int XTAL_CYC = `SMPFS_XTAL_CYC,
  parameter int PER_BASE = `SMPFS_PER_BASE
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  // CPU requests
  input  wire logic                   stop_req,
  input  wire logic                   wake_irq,
  input  wire logic                   pfd_wr,
  input  wire logic                   pfd_wdata,
  input  wire logic [1:0]             pf_interval,
  input  wire logic                   pf_prio_high,
  input  wire logic                   pfi_clr,
  // Analogue comparators, asynchronous
  input  wire smpfs_pkg::smpfs_cmp_t  cmp_raw,
  // Power control
  output smpfs_pkg::smpfs_pwr_t       pwr,
  // CPU control and status
  output logic                        cpu_rst,
  output logic                        cpu_halt,
  output logic                        stop_exit,
  output logic                        vector_pf,
  output logic                        rom_restart,
  output logic [15:0]                 restart_addr,
  output logic                        pfi_flag,
  output logic                        stop_monitor_disable
);
  import smpfs_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] per_len(input logic [1:0] sel);
    per_len = 16'(PER_BASE << (sel - 2'h1));
  endfunction : per_len

  function automatic logic in_set(input smpfs_state_t s, input logic [8:0] set);
    in_set = set[s];
  endfunction : in_set

  localparam logic [8:0] MON_SET  = 9'h0db; // RUN, STOP_MON, WAKE_CHK, WARM, PER_DET, PER_CONF
  localparam logic [8:0] RST_SET  = 9'h1e0; // PER_OFF, PER_DET, PER_CONF, POR
  localparam logic [8:0] HALT_SET = 9'h00e; // STOP_MON, STOP_OFF, WAKE_CHK

  smpfs_cmp_t   cmp_s;
  smpfs_state_t state;
  smpfs_state_t next_state;
  logic         next_warm_rst;
  logic         warm_rst;
  logic [15:0]  ring_div;
  logic [15:0]  cnt;
  logic         ring_tick;
  logic         settle_done;
  logic         warm_done;
  logic         chg;
  logic         pfi_set;
  logic         pfd_written;

  // ----------------------------------------------------------------
  // Comparator synchronisers
  // ----------------------------------------------------------------
  smpfs_sync #(
    .WIDTH (3),
    .INIT  (3'h7)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      (cmp_raw),
    .q      (cmp_s)
  );

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  assign chg         = (state != next_state);
  assign ring_tick   = (ring_div == 16'(RING_CYC - 1));
  assign settle_done = (cnt == 16'(`SMPFS_WAKE_SETTLE - 1));
  assign warm_done   = (cnt == 16'(XTAL_CYC - 1));

  // Ring periods restart with each state so detection windows are whole
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ring_div <= 16'h0000;
    end else if (chg || ring_tick) begin
      ring_div <= 16'h0000;
    end else begin
      ring_div <= ring_div + 16'h0001;
    end
  end

  // Clocks in settle and warm-up, ring periods in periodic states
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 16'h0000;
    end else if (chg) begin
      cnt <= 16'h0000;
    end else if (state == ST_WAKE_CHK || state == ST_WARM) begin
      cnt <= cnt + 16'h0001;
    end else if (ring_tick) begin
      cnt <= cnt + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (!cmp_s.por_ok) begin
      next_state = ST_POR;
    end else begin
      case (state)
        ST_RUN: begin
          if (stop_req) begin
            next_state = stop_monitor_disable ? ST_STOP_OFF : ST_STOP_MON;
          end
        end
        ST_STOP_MON: begin
          if (!cmp_s.rst_ok) begin
            next_state = ST_PER_OFF;
          end else if (!cmp_s.warn_ok || wake_irq) begin
            next_state = ST_WARM;
          end
        end
        ST_STOP_OFF: begin
          if (wake_irq) begin
            next_state = ST_WAKE_CHK;
          end
        end
        ST_WAKE_CHK: begin
          if (settle_done) begin
            next_state = cmp_s.rst_ok ? ST_WARM : ST_PER_OFF;
          end
        end
        ST_WARM: begin
          if (warm_done) begin
            next_state = ST_RUN;
          end
        end
        ST_PER_OFF: begin
          if (pf_interval == 2'h0 || (ring_tick && cnt == per_len(pf_interval) - 16'h0001)) begin
            next_state = ST_PER_DET;
          end
        end
        ST_PER_DET: begin
          if (ring_tick && cnt == 16'(`SMPFS_DET_RINGS - 1)) begin
            next_state = cmp_s.rst_ok ? ST_PER_CONF : ST_PER_OFF;
          end
        end
        ST_PER_CONF: begin
          if (!cmp_s.rst_ok) begin
            next_state = ST_PER_OFF;
          end else if (ring_tick && cnt == 16'(`SMPFS_CONF_RINGS - 1)) begin
            next_state = ST_WARM;
          end
        end
        ST_POR: begin
          next_state = ST_PER_DET;
        end
        default: begin
          next_state = ST_POR;
        end
      endcase
    end
  end

  always_comb begin
    next_warm_rst = warm_rst;
    if (next_state == ST_WARM && state != ST_WARM) begin
      next_warm_rst = (state == ST_PER_CONF);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state    <= ST_POR;
      warm_rst <= 1'b1;
    end else begin
      state    <= next_state;
      warm_rst <= next_warm_rst;
    end
  end

  // ----------------------------------------------------------------
  // Power and CPU control, registered from the next state
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr      <= '0;
      cpu_rst  <= 1'b1;
      cpu_halt <= 1'b0;
    end else begin
      pwr.mon_en   <= in_set(next_state, MON_SET);
      pwr.reg_en   <= (next_state == ST_RUN || next_state == ST_WARM);
      pwr.xtal_en  <= (next_state == ST_RUN || next_state == ST_WARM);
      pwr.sram_ret <= (next_state != ST_POR);
      cpu_rst      <= in_set(next_state, RST_SET) || (next_state == ST_WARM && next_warm_rst);
      cpu_halt     <= in_set(next_state, HALT_SET) || (next_state == ST_WARM && !next_warm_rst);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stop_exit    <= 1'b0;
      rom_restart  <= 1'b0;
      vector_pf    <= 1'b0;
      restart_addr <= `SMPFS_ROM_ADDR;
    end else begin
      stop_exit    <= (state == ST_WARM && warm_done && cmp_s.por_ok && !warm_rst);
      rom_restart  <= (state == ST_WARM && warm_done && cmp_s.por_ok && warm_rst);
      vector_pf    <= (state == ST_WARM && warm_done && cmp_s.por_ok && !warm_rst && pfi_flag && pf_prio_high);
      restart_addr <= `SMPFS_ROM_ADDR;
    end
  end

  // ----------------------------------------------------------------
  // Power-fail interrupt flag, set wins over clear
  // ----------------------------------------------------------------
  assign pfi_set = cmp_s.por_ok && cmp_s.rst_ok && !cmp_s.warn_ok &&
                   ((state == ST_WAKE_CHK && settle_done) || state == ST_STOP_MON);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pfi_flag <= 1'b0;
    end else if (pfi_set) begin
      pfi_flag <= 1'b1;
    end else if (pfi_clr) begin
      pfi_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stop_monitor_disable <= `SMPFS_PFD_RST;
      pfd_written          <= 1'b0;
    end else if (pfd_wr) begin
      stop_monitor_disable <= pfd_wdata;
      pfd_written          <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_stop_mon_power;
    state == ST_STOP_MON |-> pwr.mon_en && !pwr.reg_en && !pwr.xtal_en && pwr.sram_ret && cpu_halt;
  endproperty
  a_stop_mon_power: assert property (p_stop_mon_power) else $error("monitored stop power wrong");

  property p_dip_ignored;
    state == ST_STOP_MON && cmp_s == 3'h7 && !wake_irq |=> state == ST_STOP_MON && !stop_exit;
  endproperty
  a_dip_ignored: assert property (p_dip_ignored) else $error("stop left without cause");

  property p_warn_wake;
    state == ST_STOP_MON && cmp_s == 3'h6 |=> state == ST_WARM && pwr.reg_en && pwr.xtal_en && !cpu_rst;
  endproperty
  a_warn_wake: assert property (p_warn_wake) else $error("warning did not start warm-up");

  property p_mon_rst;
    state == ST_STOP_MON && cmp_s.por_ok && !cmp_s.rst_ok |=> state == ST_PER_OFF && cpu_rst && !pwr.mon_en;
  endproperty
  a_mon_rst: assert property (p_mon_rst) else $error("reset level did not reset cpu");

  property p_por_hold;
    !cmp_s.por_ok |=> cpu_rst && !pwr.mon_en && !pwr.reg_en && !pwr.xtal_en;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("below power-on not held");

  property p_stop_off;
    state == ST_STOP_OFF && cmp_s.por_ok && !wake_irq |=> state == ST_STOP_OFF && !pwr.mon_en && !pwr.reg_en;
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("unmonitored stop reacted");

  property p_wake_flag;
    state == ST_WAKE_CHK && settle_done && cmp_s == 3'h6 |=> pfi_flag && state == ST_WARM;
  endproperty
  a_wake_flag: assert property (p_wake_flag) else $error("power-fail flag not set on wake");

  property p_exit_powered;
    stop_exit |-> pwr.reg_en && pwr.xtal_en && $past(state) == ST_WARM && (!vector_pf || $past(pf_prio_high));
  endproperty
  a_exit_powered: assert property (p_exit_powered) else $error("stop exit without warm-up");

  property p_wake_rst;
    state == ST_WAKE_CHK && settle_done && cmp_s.por_ok && !cmp_s.rst_ok |=> cpu_rst && state == ST_PER_OFF;
  endproperty
  a_wake_rst: assert property (p_wake_rst) else $error("wake below reset level not reset");

  property p_pfd_default;
    !pfd_written |-> stop_monitor_disable;
  endproperty
  a_pfd_default: assert property (p_pfd_default) else $error("monitor disable not one after reset");

  property p_conf_needs_ok;
    state == ST_PER_DET && next_state == ST_PER_CONF |-> cmp_s.rst_ok && ring_tick && cnt == 16'h0001;
  endproperty
  a_conf_needs_ok: assert property (p_conf_needs_ok) else $error("confirm entered without two periods");

  property p_warm_gate;
    state == ST_WARM && next_state == ST_RUN |-> cnt == 16'(XTAL_CYC - 1) ##1 (stop_exit || rom_restart);
  endproperty
  a_warm_gate: assert property (p_warm_gate) else $error("warm-up left early");

  c_warn_exit: cover property (state == ST_STOP_MON ##1 state == ST_WARM);
  c_wake_reset: cover property (state == ST_WAKE_CHK ##1 state == ST_PER_OFF);
  c_rom_restart: cover property (rom_restart);
  c_vector_pf: cover property (stop_exit && vector_pf);

endmodule : smpfs_seq

/* testbench/smpfs_host_model.sv */
// Model of the CPU requests and the supply comparators facing the sequencer
`timescale 1ns/1ps
module smpfs_host_model (
  // Clock
  input  wire logic             clk,
  // CPU requests
  output logic                  stop_req,
  output logic                  wake_irq,
  // Comparator levels
  output smpfs_pkg::smpfs_cmp_t cmp_raw
);
  import smpfs_pkg::*;

  // ----------------------------------------------------------------
  // Supply level
  // ----------------------------------------------------------------
  // 3 above warning, 2 warning band, 1 reset band, 0 below power-on
  logic [1:0] level;

  assign cmp_raw = {level >= 2'h1, level >= 2'h2, level == 2'h3};

  initial begin
    stop_req = 1'b0;
    wake_irq = 1'b0;
    level    = 2'h3;
  end

  // ----------------------------------------------------------------
  // Requests, all launched on the falling edge
  // ----------------------------------------------------------------
  task automatic set_level(input logic [1:0] lvl);
    @(negedge clk);
    level = lvl;
  endtask : set_level

  // One-cycle dip, too short for the synchroniser to resolve
  task automatic dip(input logic [1:0] lvl);
    logic [1:0] keep;
    keep = level;
    @(negedge clk);
    level = lvl;
    @(negedge clk);
    level = keep;
  endtask : dip

  task automatic pulse_stop();
    @(negedge clk);
    stop_req = 1'b1;
    @(negedge clk);
    stop_req = 1'b0;
  endtask : pulse_stop

  task automatic pulse_wake();
    @(negedge clk);
    wake_irq = 1'b1;
    @(negedge clk);
    wake_irq = 1'b0;
  endtask : pulse_wake
endmodule : smpfs_host_model

/* testbench/smpfs_seq_tb.sv */
// Self-checking testbench of the stop-mode power-fail sequencer
`timescale 1ns/1ps
module smpfs_seq_tb;
  import smpfs_pkg::*;
  localparam int RING_CYC = 4;
  localparam int XTAL_CYC = 8;
  localparam int PER_BASE = 2;

  logic        clk, arst_n, stop_req, wake_irq, pfd_wr, pfd_wdata, pf_prio_high, pfi_clr;
  logic [1:0]  pf_interval;
  logic        cpu_rst, cpu_halt, stop_exit, vector_pf, rom_restart, pfi_flag, stop_monitor_disable;
  logic [15:0] restart_addr;
  smpfs_cmp_t  cmp_raw;
  smpfs_pwr_t  pwr;
  int          n_mismatch, check_count, n;

  smpfs_seq #(.RING_CYC(RING_CYC), .XTAL_CYC(XTAL_CYC), .PER_BASE(PER_BASE)) smpfs_seq_inst (
    .clk(clk), .arst_n(arst_n), .stop_req(stop_req), .wake_irq(wake_irq), .pfd_wr(pfd_wr),
    .pfd_wdata(pfd_wdata), .pf_interval(pf_interval), .pf_prio_high(pf_prio_high), .pfi_clr(pfi_clr),
    .cmp_raw(cmp_raw), .pwr(pwr), .cpu_rst(cpu_rst), .cpu_halt(cpu_halt), .stop_exit(stop_exit),
    .vector_pf(vector_pf), .rom_restart(rom_restart), .restart_addr(restart_addr), .pfi_flag(pfi_flag),
    .stop_monitor_disable(stop_monitor_disable));

  smpfs_host_model smpfs_host_model_inst (.clk(clk), .stop_req(stop_req), .wake_irq(wake_irq), .cmp_raw(cmp_raw));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Compare, wait and close
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  task automatic fail(input string what);
    n_mismatch++;
    $display("unexpected at %0t: %s", $time, what);
  endtask : fail

  task automatic chk_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) fail(what);
  endtask : chk_bit

  task automatic chk_pwr(input smpfs_pwr_t got, input smpfs_pwr_t exp, input string what);
    check_count++;
    if (got !== exp) fail(what);
  endtask : chk_pwr

  task automatic chk_addr(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) fail(what);
  endtask : chk_addr

  // Waits on falling edges for a chosen output to be high (monitor enable low for other selects), cnt edges passed
  task automatic wait_sig(input int sel, input int bound, output int cnt);
    logic v;
    cnt = 0;
    for (int i = 0; i <= bound; i++) begin
      case (sel)
        0: v = cpu_halt;
        1: v = cpu_rst;
        2: v = stop_exit;
        3: v = rom_restart;
        4: v = pwr.mon_en;
        5: v = pfi_flag;
        6: v = pwr.xtal_en;
        default: v = ~pwr.mon_en;
      endcase
      if (v === 1'b1) begin
        cnt = i;
        check_count++;
        return;
      end
      @(negedge clk);
    end
    fail($sformatf("wait %0d timed out", sel));
    close_out();
  endtask : wait_sig

  task automatic pulse_ctl(input int sel, input logic val);
    @(negedge clk);
    if (sel == 0) pfd_wr = 1'b1;
    if (sel == 0) pfd_wdata = val;
    if (sel == 1) pfi_clr = 1'b1;
    @(negedge clk);
    pfd_wr = 1'b0;
    pfi_clr = 1'b0;
  endtask : pulse_ctl

  task automatic recover();
    smpfs_host_model_inst.set_level(2'h3);
    wait_sig(3, 400, n);
    chk_addr(restart_addr, 16'h8000, "restart address");
    @(negedge clk);
    chk_bit(cpu_rst, 1'b0, "reset not released");
  endtask : recover

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_boot();
    chk_bit(stop_monitor_disable, 1'b1, "disable reset value");
    chk_pwr(pwr, 4'h0, "power on in reset");
    chk_bit(cpu_rst, 1'b1, "cpu not in reset");
    arst_n = 1'b1;
    wait_sig(4, 40, n);
    wait_sig(6, 200, n);
    chk_bit(n >= 3 * RING_CYC - 1, 1'b1, "detection too short");
    wait_sig(3, 40, n);
    chk_bit(n >= XTAL_CYC - 1 && n <= XTAL_CYC + 1, 1'b1, "warm-up length");
    chk_addr(restart_addr, 16'h8000, "restart address");
    chk_bit(cpu_rst, 1'b0, "reset not released");
    $display("test boot done");
  endtask : t_boot

  task automatic t_stop_off(input logic prio);
    pf_prio_high = prio;
    smpfs_host_model_inst.pulse_stop();
    wait_sig(0, 10, n);
    chk_pwr(pwr, 4'b0001, "stop power, monitor off");
    smpfs_host_model_inst.set_level(2'h1);
    repeat (20) @(negedge clk);
    chk_pwr(pwr, 4'b0001, "reacted to low supply");
    chk_bit(cpu_rst, 1'b0, "reset while monitor off");
    chk_bit(pfi_flag, 1'b0, "flag while monitor off");
    smpfs_host_model_inst.set_level(2'h2);
    repeat (8) @(negedge clk);
    smpfs_host_model_inst.pulse_wake();
    wait_sig(4, 10, n);
    wait_sig(5, 20, n);
    wait_sig(6, 20, n);
    chk_bit(pwr.reg_en, 1'b1, "regulator off in warm-up");
    wait_sig(2, 20, n);
    chk_bit(n >= XTAL_CYC - 1 && n <= XTAL_CYC + 1, 1'b1, "warm-up length");
    chk_bit(vector_pf, prio, "vector choice");
    chk_bit(cpu_halt, 1'b0, "still halted");
    pulse_ctl(1, 1'b0);
    chk_bit(pfi_flag, 1'b0, "flag not cleared");
    smpfs_host_model_inst.set_level(2'h3);
    repeat (8) @(negedge clk);
    $display("test stop_off done");
  endtask : t_stop_off

  task automatic t_stop_mon();
    pulse_ctl(0, 1'b0);
    chk_bit(stop_monitor_disable, 1'b0, "disable write");
    smpfs_host_model_inst.pulse_stop();
    wait_sig(0, 10, n);
    chk_pwr(pwr, 4'b1001, "stop power, monitor on");
    smpfs_host_model_inst.dip(2'h2);
    repeat (20) @(negedge clk);
    chk_pwr(pwr, 4'b1001, "dip changed power");
    chk_bit(pfi_flag, 1'b0, "dip raised warning");
    chk_bit(cpu_halt, 1'b1, "dip left stop");
    smpfs_host_model_inst.set_level(2'h2);
    wait_sig(6, 20, n);
    chk_pwr(pwr, 4'b1111, "warm-up power");
    wait_sig(2, 20, n);
    chk_bit(n >= XTAL_CYC - 1 && n <= XTAL_CYC + 1, 1'b1, "warm-up length");
    chk_bit(cpu_halt, 1'b0, "still halted");
    pulse_ctl(1, 1'b0);
    smpfs_host_model_inst.set_level(2'h3);
    repeat (8) @(negedge clk);
    $display("test stop_mon done");
  endtask : t_stop_mon

  task automatic t_stop_rst();
    pf_interval = 2'h2;
    smpfs_host_model_inst.pulse_stop();
    wait_sig(0, 10, n);
    smpfs_host_model_inst.set_level(2'h1);
    wait_sig(1, 20, n);
    chk_bit(pwr.xtal_en, 1'b0, "crystal on in reset");
    wait_sig(7, 60, n);
    wait_sig(4, 200, n);
    chk_bit(n == (PER_BASE << 1) * RING_CYC, 1'b1, "off interval length");
    recover();
    $display("test stop_rst done");
  endtask : t_stop_rst

  task automatic t_wake_rst();
    pf_interval = 2'h0;
    pulse_ctl(0, 1'b1);
    smpfs_host_model_inst.pulse_stop();
    wait_sig(0, 10, n);
    smpfs_host_model_inst.set_level(2'h1);
    repeat (8) @(negedge clk);
    smpfs_host_model_inst.pulse_wake();
    wait_sig(1, 30, n);
    wait_sig(7, 60, n);
    wait_sig(4, 1, n);
    recover();
    pf_interval = 2'h1;
    $display("test wake_rst done");
  endtask : t_wake_rst

  task automatic t_por();
    smpfs_host_model_inst.set_level(2'h0);
    wait_sig(1, 20, n);
    repeat (4) @(negedge clk);
    chk_pwr(pwr, 4'h0, "power on below power-on level");
    chk_bit(cpu_rst, 1'b1, "not held in reset");
    recover();
    $display("test por done");
  endtask : t_por

  task automatic t_reset();
    pulse_ctl(0, 1'b0);
    @(negedge clk);
    arst_n = 1'b0;
    @(negedge clk);
    chk_bit(stop_monitor_disable, 1'b1, "disable not reset");
    chk_bit(cpu_rst, 1'b1, "reset not applied");
    arst_n = 1'b1;
    recover();
    $display("test reset done");
  endtask : t_reset

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    n_mismatch   = 0;
    check_count  = 0;
    arst_n       = 1'b0;
    pfd_wr       = 1'b0;
    pfd_wdata    = 1'b0;
    pfi_clr      = 1'b0;
    pf_prio_high = 1'b0;
    pf_interval  = 2'h1;
    repeat (16) @(negedge clk);
    t_boot();
    t_stop_off(1'b1);
    t_stop_off(1'b0);
    t_stop_mon();
    t_stop_rst();
    t_wake_rst();
    t_por();
    t_reset();
    close_out();
  end
endmodule : smpfs_seq_tb
